// ==== core/pmp_pkg.sv ====
// shared constants and types of the indicator pin and mac data port
package pmp_pkg;
  // basic control register and its speed-select field
  localparam logic [7:0] BASIC_CTRL_OFS     = 8'h00;
  localparam int         SPEED_SEL_POS      = 13;
  // vendor control register and its indicator-mode field
  localparam logic [7:0] VENDOR_CTRL_OFS    = 8'h1e;
  localparam int         IND_MODE_MSB       = 15;
  localparam int         IND_MODE_LSB       = 14;
  // configuration strap codes
  localparam logic [2:0] CFG_MII            = 3'h0;
  localparam logic [2:0] CFG_RMII           = 3'h1;
  localparam logic [2:0] CFG_LOOP           = 3'h4;
  // values after reset
  localparam logic       SPEED_RST          = 1'b0;
  localparam logic [2:0] CFG_RST            = 3'h0;
  localparam logic       LED_RST            = 1'b1;
  // cycles the pin synchroniser needs before the strap is trusted
  localparam logic [1:0] STRAP_SETTLE_CYC   = 2'h2;
  // link-side activity stretch, long enough for two system clocks
  localparam logic [2:0] ACT_STRETCH_CYC    = 3'h4;
  // blink half period
  localparam int         CLK_HZ             = 20_000_000;
  localparam int         BLINK_HALF_MS      = 100;
  localparam int         BLINK_HALF_CYC     = CLK_HZ / 1000 * BLINK_HALF_MS;

  typedef enum logic [1:0] {
    IND_SPEED = 2'b00,
    IND_ACT   = 2'b01,
    IND_RSV2  = 2'b10,
    IND_RSV3  = 2'b11
  } pmp_ind_mode_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_LATCH  = 2'b01,
    ST_RUN    = 2'b10
  } pmp_strap_st_t;
endpackage

// ==== core/pmp_link_if.sv ====
// signals passed between the system-clock core and the link-clock logic
`timescale 1ns/1ps
interface pmp_link_if;
  logic [2:0] cfg_mode;
  logic       cfg_ok;
  logic       activity;

  modport core (output cfg_mode, output cfg_ok, input  activity);
  modport link (input  cfg_mode, input  cfg_ok, output activity);
endinterface

// ==== core/pmp_sync.sv ====
// two-flop level synchroniser
`timescale 1ns/1ps
module pmp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // pmp_sync

// ==== core/pmp_link.sv ====
// link-clock data path: mii/rmii receive drive and transmit capture
`timescale 1ns/1ps
module pmp_link
  import pmp_pkg::*;
(
  // clock and reset
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  // crossing to the core
  pmp_link_if.link        lif,
  // mac side
  input  wire logic [3:0] txd_i,
  input  wire logic       tx_en_i,
  output logic      [3:0] rxd_o,
  output logic            rx_dv_o,
  // transceiver core side
  input  wire logic [3:0] rx_data_i,
  input  wire logic       rx_valid_i,
  output logic      [3:0] tx_data_o,
  output logic            tx_valid_o
);
  logic [3:0] cfg_s;
  logic [2:0] act_cnt_reg;
  logic       rmii;
  logic       loop;

  // mode is static after the strap latch, so a bus synchroniser is safe
  pmp_sync #(.W(4)) u_cfg_sync (
    .clk_i (link_clk_i),
    .rst_i (rst_i),
    .d_i   ({lif.cfg_ok, lif.cfg_mode}),
    .q_o   (cfg_s)
  );

  assign rmii = cfg_s[3] && (cfg_s[2:0] == CFG_RMII);
  assign loop = cfg_s[3] && (cfg_s[2:0] == CFG_LOOP);

  // receive drive, registered on the link clock
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_o   <= 4'h0;
      rx_dv_o <= 1'b0;
    end else if (!cfg_s[3]) begin
      rxd_o   <= 4'h0;
      rx_dv_o <= 1'b0;
    end else if (loop) begin
      rxd_o   <= tx_en_i ? txd_i : 4'h0;
      rx_dv_o <= tx_en_i;
    end else if (rmii) begin
      rxd_o   <= rx_valid_i ? {2'h0, rx_data_i[1:0]} : 4'h0;
      rx_dv_o <= rx_valid_i;
    end else begin
      rxd_o   <= rx_valid_i ? rx_data_i : 4'h0;
      rx_dv_o <= rx_valid_i;
    end
  end

  // transmit capture; the mac drives txd on this same edge
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_data_o  <= 4'h0;
      tx_valid_o <= 1'b0;
    end else begin
      tx_valid_o <= tx_en_i && cfg_s[3] && !loop;
      if (tx_en_i && cfg_s[3]) begin
        tx_data_o <= rmii ? {2'h0, txd_i[1:0]} : txd_i;
      end
    end
  end

  // stretched so a one-cycle frame still crosses to the slower clock
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_cnt_reg <= 3'h0;
    end else if (tx_en_i || rx_valid_i) begin
      act_cnt_reg <= ACT_STRETCH_CYC;
    end else if (act_cnt_reg != 3'h0) begin
      act_cnt_reg <= act_cnt_reg - 3'h1;
    end
  end
  assign lif.activity = (act_cnt_reg != 3'h0);

  rx_mii_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (cfg_s[3] && !rmii && !loop && !rx_valid_i) |=> (!rx_dv_o && rxd_o == 4'h0))
    else $error("mii receive valid or data without a valid nibble");
  rx_nibble_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (cfg_s[3] && !rmii && !loop && rx_valid_i) |=> (rx_dv_o && rxd_o == $past(rx_data_i)))
    else $error("mii receive nibble not passed on");
  rx_dibit_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (rmii && rx_valid_i) |=> (rx_dv_o && rxd_o == {2'h0, $past(rx_data_i[1:0])}))
    else $error("rmii receive dibit not passed on");
  tx_ignore_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    !tx_en_i |=> ($stable(tx_data_o) && !tx_valid_o))
    else $error("transmit data changed while enable low");
  tx_dibit_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (rmii && tx_en_i) |=> (tx_valid_o && tx_data_o[1:0] == $past(txd_i[1:0])))
    else $error("rmii transmit dibit not captured");
  rmii_frame_c: cover property (@(posedge link_clk_i) disable iff (rst_i)
    rmii && tx_en_i [*3] ##1 !tx_en_i);
  loop_frame_c: cover property (@(posedge link_clk_i) disable iff (rst_i)
    loop && tx_en_i ##1 rx_dv_o);
endmodule // pmp_link

// ==== core/pmp_phy_port.sv ====
// indicator/strap pin and mac data port of a 10/100 transceiver
// Operation
// - speed-select bit is loaded from the indicator pin level at reset.
// - indicator behaviour follows the two-bit indicator-mode field.
// - mode 00: high at 10, low at 100; mode 01: high idle, toggle on activity.
// - strap pin is an input during reset, an output after release.
// - mii receive nibbles change on the receive clock.
// - mii receive nibbles are valid only while receive-valid is high.
// - rmii sends two receive bits per clock while carrier/valid is high.
// - mii transmit lines are ignored while transmit enable is low.
// - rmii transmit: two bits per clock captured while enable is high.
// - rmii receive lines are driven on the shared reference clock.
// - three-bit config strap latched at reset: mii, rmii, pcs loopback.
`timescale 1ns/1ps
module pmp_phy_port
  import pmp_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  // system clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       RST_I,
  // link clock: mii receive/transmit clock or rmii reference clock
  input  wire logic       LINK_CLK_I,
  // shared indicator/speed strap pin
  input  wire logic       SECOND_INDICATOR_IN_I,
  output logic            SECOND_INDICATOR_OUT_O,
  output logic            SECOND_INDICATOR_OE_O,
  // configuration strap pins
  input  wire logic [2:0] CONFIG_STRAP_I,
  // indicator-mode field, system clock domain
  input  wire logic [1:0] INDICATOR_MODE_I,
  // latched strap state
  output logic            SPEED_SELECT_O,
  output logic      [2:0] IF_MODE_O,
  output logic            STRAP_DONE_O,
  // mac side of the data port
  input  wire logic [3:0] TXD_I,
  input  wire logic       MII_TRANSMIT_ENABLE_I,
  output logic      [3:0] RXD_O,
  output logic            MII_RECEIVE_VALID_O,
  // transceiver core side, link clock domain
  input  wire logic [3:0] RX_DATA_I,
  input  wire logic       RX_VALID_I,
  output logic      [3:0] TX_DATA_O,
  output logic            TX_VALID_O
);
  localparam logic [23:0] BLINK_LAST = 24'(BLINK_HALF - 1);

  pmp_link_if    lif ();
  pmp_strap_st_t st_reg;
  pmp_strap_st_t st_next;
  logic [1:0]    settle_cnt_reg;
  logic [3:0]    pins_s;
  logic          act_s;
  logic          speed_reg;
  logic [2:0]    cfg_reg;
  logic          led_reg;
  logic          led_next;
  logic [23:0]   blink_cnt_reg;
  logic          blink_reg;
  pmp_ind_mode_t ind_mode;

  assign ind_mode = pmp_ind_mode_t'(INDICATOR_MODE_I);

  // strap pins come from outside, so they pass two flops first
  pmp_sync #(.W(4)) u_pin_sync (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .d_i   ({SECOND_INDICATOR_IN_I, CONFIG_STRAP_I}),
    .q_o   (pins_s)
  );

  pmp_sync #(.W(1)) u_act_sync (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .d_i   (lif.activity),
    .q_o   (act_s)
  );

  pmp_link u_link (
    .link_clk_i (LINK_CLK_I),
    .rst_i      (RST_I),
    .lif        (lif.link),
    .txd_i      (TXD_I),
    .tx_en_i    (MII_TRANSMIT_ENABLE_I),
    .rxd_o      (RXD_O),
    .rx_dv_o    (MII_RECEIVE_VALID_O),
    .rx_data_i  (RX_DATA_I),
    .rx_valid_i (RX_VALID_I),
    .tx_data_o  (TX_DATA_O),
    .tx_valid_o (TX_VALID_O)
  );

  // strap sequencer: wait for the synchroniser, latch once, then run
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_SETTLE: begin
        if (settle_cnt_reg == STRAP_SETTLE_CYC) begin
          st_next = ST_LATCH;
        end
      end
      ST_LATCH: begin
        st_next = ST_RUN;
      end
      ST_RUN: begin
        st_next = ST_RUN;
      end
      default: begin
        st_next = ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= ST_SETTLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      settle_cnt_reg <= 2'h0;
    end else if (st_reg == ST_SETTLE && settle_cnt_reg != STRAP_SETTLE_CYC) begin
      settle_cnt_reg <= settle_cnt_reg + 2'h1;
    end
  end

  // the strap is caught after release, never as a reset value
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      speed_reg <= SPEED_RST;
      cfg_reg   <= CFG_RST;
    end else if (st_reg == ST_LATCH) begin
      speed_reg <= pins_s[3];
      cfg_reg   <= pins_s[2:0];
    end
  end

  assign lif.cfg_mode = cfg_reg;
  assign lif.cfg_ok   = (st_reg == ST_RUN);

  // blink timer runs only while activity is seen
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      blink_cnt_reg <= 24'h0;
      blink_reg     <= LED_RST;
    end else if (!act_s) begin
      blink_cnt_reg <= 24'h0;
      blink_reg     <= LED_RST;
    end else if (blink_cnt_reg == BLINK_LAST) begin
      blink_cnt_reg <= 24'h0;
      blink_reg     <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 24'h1;
    end
  end

  // reserved modes leave the indicator off
  always_comb begin
    led_next = LED_RST;
    case (ind_mode)
      IND_SPEED: begin
        led_next = !speed_reg;
      end
      IND_ACT: begin
        led_next = blink_reg;
      end
      default: begin
        led_next = LED_RST;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      led_reg <= LED_RST;
    end else begin
      led_reg <= led_next;
    end
  end

  assign SECOND_INDICATOR_OUT_O = led_reg;
  assign SECOND_INDICATOR_OE_O  = (st_reg == ST_RUN);
  assign SPEED_SELECT_O         = speed_reg;
  assign IF_MODE_O              = cfg_reg;
  assign STRAP_DONE_O           = (st_reg == ST_RUN);

  speed_latch_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (st_reg == ST_LATCH) |=> (speed_reg == $past(pins_s[3])))
    else $error("speed select not loaded from indicator pin");
  speed_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (st_reg == ST_RUN) |=> $stable(speed_reg))
    else $error("speed select changed after strap latch");
  mode_latch_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (st_reg == ST_LATCH) |=> (cfg_reg == $past(pins_s[2:0]) && STRAP_DONE_O))
    else $error("config strap not latched");
  pin_input_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (st_reg != ST_RUN) |-> !SECOND_INDICATOR_OE_O)
    else $error("strap pin driven before latch");
  pin_output_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    SECOND_INDICATOR_OE_O |=> SECOND_INDICATOR_OE_O)
    else $error("strap pin released after latch");
  release_time_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (st_reg == ST_SETTLE) |-> ##[1:4] STRAP_DONE_O)
    else $error("strap latch late after reset release");
  led_speed_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (ind_mode == IND_SPEED) |=> (SECOND_INDICATOR_OUT_O == !$past(speed_reg)))
    else $error("speed indicator level wrong");
  led_idle_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (ind_mode == IND_ACT && !act_s) |=> ##1 SECOND_INDICATOR_OUT_O)
    else $error("activity indicator not high when idle");
  led_reserved_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (ind_mode == IND_RSV2 || ind_mode == IND_RSV3) |=> SECOND_INDICATOR_OUT_O)
    else $error("reserved indicator mode not off");
  blink_flip_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (act_s && blink_cnt_reg == BLINK_LAST) |=> (blink_reg != $past(blink_reg)))
    else $error("activity indicator did not toggle");

  blink_c: cover property (@(posedge MCLK_I) disable iff (RST_I)
    ind_mode == IND_ACT && act_s && $changed(blink_reg));
  strap_c: cover property (@(posedge MCLK_I) disable iff (RST_I)
    $rose(STRAP_DONE_O) && IF_MODE_O == CFG_RMII);
  speed100_c: cover property (@(posedge MCLK_I) disable iff (RST_I)
    STRAP_DONE_O && speed_reg && !SECOND_INDICATOR_OUT_O);
endmodule // pmp_phy_port

// ==== verification/pmp_mac_model.sv ====
// mac-side model: drives transmit nibbles or dibits on the link clock
`timescale 1ns/1ps
module pmp_mac_model (
  // link clock
  input  wire logic       link_clk_i,
  // transmit lines toward the device
  output logic      [3:0] txd_o,
  output logic            tx_en_o
);
  initial begin
    txd_o   = 4'h0;
    tx_en_o = 1'b0;
  end

  // one link cycle; idle lines carry the inverse so stale data never passes for valid
  task automatic drive(input logic [3:0] d, input logic en);
    @(posedge link_clk_i);
    tx_en_o <= en;
    txd_o   <= en ? d : ~txd_o;
  endtask
endmodule // pmp_mac_model

// ==== verification/tb.sv ====
// self-checking bench of the indicator pin and mac data port
`timescale 1ns/1ps
module tb;
  import pmp_pkg::*;
  logic       mclk = 1'b0;
  logic       lclk = 1'b0;
  logic       rst;
  logic       spd_pin;
  logic       pin;
  logic       ind_out;
  logic       ind_oe;
  logic [2:0] strap;
  logic [1:0] mode;
  logic       speed;
  logic [2:0] ifm;
  logic       done;
  logic [3:0] txd;
  logic       tx_en;
  logic [3:0] rxd;
  logic       rx_dv;
  logic [3:0] rx_data;
  logic       rx_valid;
  logic [3:0] tx_data;
  logic       tx_valid;
  int         err_total;
  int         cmp_count;

  always #25 mclk = ~mclk;
  always #15 lclk = ~lclk;
  // strap level from spd_pin unless the device drives the pin
  assign pin = ind_oe ? ind_out : spd_pin;

  pmp_phy_port #(.BLINK_HALF(8)) i_dut (
    .MCLK_I(mclk), .RST_I(rst), .LINK_CLK_I(lclk),
    .SECOND_INDICATOR_IN_I(pin), .SECOND_INDICATOR_OUT_O(ind_out), .SECOND_INDICATOR_OE_O(ind_oe),
    .CONFIG_STRAP_I(strap), .INDICATOR_MODE_I(mode),
    .SPEED_SELECT_O(speed), .IF_MODE_O(ifm), .STRAP_DONE_O(done),
    .TXD_I(txd), .MII_TRANSMIT_ENABLE_I(tx_en), .RXD_O(rxd), .MII_RECEIVE_VALID_O(rx_dv),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid)
  );

  pmp_mac_model i_mac (.link_clk_i(lclk), .txd_o(txd), .tx_en_o(tx_en));

  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset with given straps, then wait for the latch and the link-side crossing
  task automatic reset_strap(input logic s, input logic [2:0] c);
    @(posedge mclk);
    rst     <= 1'b1;
    spd_pin <= s;
    strap   <= c;
    repeat (20) @(posedge mclk);
    #1 check(ind_oe, 4'h0, "pin driven in reset");
    check(done, 4'h0, "strap done in reset");
    @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8 && done !== 1'b1; i++) @(posedge mclk);
    #1 check(done, 4'h1, "strap never latched");
    check(speed, 4'(s), "speed strap");
    check(ifm, 4'(c), "config strap");
    check(ind_oe, 4'h1, "pin not driven after reset");
    repeat (10) @(posedge lclk);
  endtask

  task automatic ind_test(input logic s);
    logic low_seen;
    low_seen = 1'b0;
    reset_strap(s, CFG_MII);
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      mode <= 2'(m);
      repeat (3) @(posedge mclk);
      #1 check(ind_out, (m == 0) ? 4'(!s) : 4'h1, "indicator level");
    end
    @(posedge mclk);
    mode <= IND_ACT;
    // activity must outlast a blink half period, so sample while it is still going
    @(posedge lclk);
    rx_valid <= 1'b1;
    repeat (40) @(posedge mclk) if (ind_out === 1'b0) low_seen = 1'b1;
    @(posedge lclk);
    rx_valid <= 1'b0;
    check(low_seen, 4'h1, "no blink on activity");
  endtask

  task automatic rx_test(input logic [2:0] c);
    logic [3:0] prev;
    reset_strap(1'b1, c);
    for (int i = 0; i < 5; i++) begin
      @(posedge lclk);
      rx_valid <= (i < 4);
      rx_data  <= 4'hc ^ 4'(i);
      prev = 4'hc ^ 4'(i - 1);
      #1 if (i > 0) check(rxd, (c == CFG_RMII) ? {2'b00, prev[1:0]} : prev, "rx data");
      if (i > 0) check(rx_dv, 4'h1, "rx valid");
    end
    @(posedge lclk);
    #1 check(rx_dv, 4'h0, "rx valid after end");
  endtask

  task automatic tx_test(input logic [2:0] c);
    logic [3:0] prev;
    logic [3:0] exp;
    reset_strap(1'b1, c);
    for (int i = 0; i < 6; i++) begin
      if (i < 4)
        i_mac.drive(4'ha ^ 4'(i), 1'b1);
      else
        i_mac.drive(4'h0, 1'b0);
      if (i < 5) prev = 4'ha ^ 4'(i - 1);
      exp = (c == CFG_RMII) ? {2'b00, prev[1:0]} : prev;
      #1 if (c == CFG_LOOP && i > 0) begin
        check(rxd, (i < 5) ? prev : 4'h0, "loopback data");
        check(rx_dv, 4'(i < 5), "loopback valid");
        check(tx_valid, 4'h0, "loopback tx valid");
      end
      else if (i > 0) begin
        check(tx_valid, 4'(i < 5), "tx valid");
        check(tx_data, exp, "tx data");
      end
    end
  endtask

  initial begin
    rst       = 1'b1;
    spd_pin   = 1'b1;
    strap     = CFG_MII;
    mode      = IND_SPEED;
    rx_data   = 4'h0;
    rx_valid  = 1'b0;
    err_total = 0;
    cmp_count = 0;
    ind_test(1'b1);
    ind_test(1'b0);
    rx_test(CFG_MII);
    rx_test(CFG_RMII);
    tx_test(CFG_MII);
    tx_test(CFG_RMII);
    tx_test(CFG_LOOP);
    finish_test();
  end

  // whole run takes well under half of this span
  initial begin
    #2_000_000;
    err_total++;
    finish_test();
  end
endmodule // tb
